/* rtl/scg_synth_regs.sv */
// Module: synthesizer configuration, gain and hop-table registers behind an AHB-Lite slave
// Behaviour
// - Dither bit adds sub-LSB dither before rounding.
// - Combine bit: independent or summed oscillators.
// - Summed mode feeds both oscillator channels.
// - Oscillator A gain is one minus backoff/65536.
// - Backoff applies in both combine modes.
// - Dither level adds extra gain backoff.
// - Effective gain clamps at zero.
// - Oscillator B uses its own backoff likewise.
// - Sixteen hop words, index zero lowest.
// - Cleared enable holds oscillators in reset.
// - Frequency is word times rate over 2^32.
`timescale 1ns/1ns
`default_nettype none
module scg_synth_regs
	import scg_pkg::*;
#(
	parameter int HOP_DEPTH = SCG_HOP_DEPTH
) (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	// AHB-Lite slave
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	output logic      [31:0] o_hrdata,
	output logic             o_hreadyout,
	output logic             o_hresp,
	// Synthesizer pins
	input  wire logic        i_transmit_enable,
	input  wire logic [31:0] i_freq_word_b,
	input  wire logic [15:0] i_channel_a_data,
	input  wire logic [15:0] i_channel_b_data,
	// Channel samples and status
	output logic      [15:0] o_channel_a_sample,
	output logic      [15:0] o_channel_b_sample,
	output logic             o_osc_enable,
	output logic             o_transmit_active
);

	localparam int SEL_W = $clog2(HOP_DEPTH);

	typedef struct packed {
		scg_bus_e                    bus;
		logic [11:0]                 addr;
		logic [31:0]                 rdata;
		logic [7:0]                  settings;
		logic [15:0]                 gain_a;
		logic [15:0]                 gain_b;
		logic                        osc_enable;
		logic                        tx_enable;
		logic [SEL_W-1:0]            hop_select_a;
		logic [3:0]                  dither_level_a;
		logic [3:0]                  dither_level_b;
		logic                        src_ch_a;
		logic                        src_ch_b;
		logic [15:0]                 ch_a;
		logic [15:0]                 ch_b;
		logic [HOP_DEPTH-1:0][31:0]  hop;
	} scg_state_s;

	localparam scg_state_s SCG_RST = '{
		bus:            SCG_BUS_IDLE,
		addr:           12'h000,
		rdata:          32'h0000_0000,
		settings:       SCG_SETTINGS_RST,
		gain_a:         SCG_GAIN_RST,
		gain_b:         SCG_GAIN_RST,
		osc_enable:     1'b0,
		tx_enable:      1'b0,
		hop_select_a:   '0,
		dither_level_a: 4'h0,
		dither_level_b: 4'h0,
		src_ch_a:       1'b0,
		src_ch_b:       1'b0,
		ch_a:           16'h0000,
		ch_b:           16'h0000,
		hop:            {HOP_DEPTH{SCG_HOP_RST}}
	};

	scg_state_s s_r;
	scg_state_s s_nxt;

	// Oscillator links
	scg_osc_if osc_a ();
	scg_osc_if osc_b ();

	logic             addr_take;
	logic             hop_hit;
	logic [11:0]      hop_off;
	logic [SEL_W-1:0] hop_entry;
	logic [31:0]      rd_mux;
	logic signed [16:0] osc_sum;
	logic [15:0]      osc_sum_sat;

	// Configuration to the two oscillators
	always_comb begin
		// selected hop word drives oscillator A
		osc_a.freq_word    = s_r.hop[s_r.hop_select_a];
		osc_a.gain_backoff = s_r.gain_a;
		osc_a.dither_level = s_r.dither_level_a;
		osc_a.dither_en    = s_r.settings[SCG_SET_DITHER_BIT];
		osc_a.enable       = s_r.osc_enable;
		osc_b.freq_word    = i_freq_word_b;
		osc_b.gain_backoff = s_r.gain_b;
		osc_b.dither_level = s_r.dither_level_b;
		osc_b.dither_en    = s_r.settings[SCG_SET_DITHER_BIT];
		osc_b.enable       = s_r.osc_enable;
	end

	scg_osc_chan u_osc_a (
		.i_clk  (i_clk),
		.i_nrst (i_nrst),
		.osc    (osc_a)
	);

	scg_osc_chan u_osc_b (
		.i_clk  (i_clk),
		.i_nrst (i_nrst),
		.osc    (osc_b)
	);

	// Summed oscillator with saturation so a wrap never flips the sign
	always_comb begin
		osc_sum = $signed({osc_a.sample[15], osc_a.sample}) + $signed({osc_b.sample[15], osc_b.sample});
		if (osc_sum[16] != osc_sum[15]) begin
			osc_sum_sat = osc_sum[16] ? 16'h8000 : 16'h7FFF;
		end else begin
			osc_sum_sat = osc_sum[15:0];
		end
	end

	// Hop table decode: one word per entry, every fourth index
	always_comb begin
		hop_off   = s_r.addr - SCG_IDX_HOP_BASE;
		hop_hit   = (s_r.addr >= SCG_IDX_HOP_BASE)
			&& (hop_off < 12'(SCG_HOP_STRIDE * HOP_DEPTH))
			&& (hop_off[1:0] == 2'b00);
		hop_entry = hop_off[SEL_W+1:2];
	end

	// Read multiplexer; unmapped indices read zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hop_hit) begin
			rd_mux = s_r.hop[hop_entry];
		end else begin
			unique case (s_r.addr)
				SCG_IDX_SETTINGS: begin
					rd_mux[7:0] = s_r.settings;
				end
				SCG_IDX_GAIN_A: begin
					rd_mux[15:0] = s_r.gain_a;
				end
				SCG_IDX_GAIN_B: begin
					rd_mux[15:0] = s_r.gain_b;
				end
				SCG_IDX_CONTROL: begin
					rd_mux[SCG_CTL_OSC_EN_BIT] = s_r.osc_enable;
					rd_mux[SCG_CTL_TX_EN_BIT]  = s_r.tx_enable;
					rd_mux[SCG_CTL_HOP_SEL_LSB +: SEL_W] = s_r.hop_select_a;
				end
				SCG_IDX_DITHER: begin
					rd_mux[3:0] = s_r.dither_level_a;
					rd_mux[SCG_DITH_LVL_B_LSB +: 4] = s_r.dither_level_b;
				end
				SCG_IDX_SOURCE: begin
					rd_mux[SCG_SRC_CH_A_BIT] = s_r.src_ch_a;
					rd_mux[SCG_SRC_CH_B_BIT] = s_r.src_ch_b;
				end
				SCG_IDX_STAT_GAIN_A: begin
					rd_mux[16:0] = osc_a.eff_gain;
				end
				SCG_IDX_STAT_GAIN_B: begin
					rd_mux[16:0] = osc_b.eff_gain;
				end
				default: begin
					rd_mux = 32'h0000_0000;
				end
			endcase
		end
	end

	// Next state: bus phases, register writes and channel outputs
	always_comb begin
		s_nxt     = s_r;
		addr_take = i_hsel && i_htrans[1] && i_hready;

		unique case (s_r.bus)
			SCG_BUS_WRITE: begin
				// Writes land in the data phase; hsize is ignored, whole words only
				if (hop_hit) begin
					s_nxt.hop[hop_entry] = i_hwdata;
				end else begin
					unique case (s_r.addr)
						SCG_IDX_SETTINGS: begin
							s_nxt.settings = i_hwdata[7:0];
						end
						SCG_IDX_GAIN_A: begin
							s_nxt.gain_a = i_hwdata[15:0];
						end
						SCG_IDX_GAIN_B: begin
							s_nxt.gain_b = i_hwdata[15:0];
						end
						SCG_IDX_CONTROL: begin
							s_nxt.osc_enable   = i_hwdata[SCG_CTL_OSC_EN_BIT];
							s_nxt.tx_enable    = i_hwdata[SCG_CTL_TX_EN_BIT];
							s_nxt.hop_select_a = i_hwdata[SCG_CTL_HOP_SEL_LSB +: SEL_W];
						end
						SCG_IDX_DITHER: begin
							s_nxt.dither_level_a = i_hwdata[3:0];
							s_nxt.dither_level_b = i_hwdata[SCG_DITH_LVL_B_LSB +: 4];
						end
						SCG_IDX_SOURCE: begin
							s_nxt.src_ch_a = i_hwdata[SCG_SRC_CH_A_BIT];
							s_nxt.src_ch_b = i_hwdata[SCG_SRC_CH_B_BIT];
						end
						default: begin
							s_nxt.addr = s_r.addr; // Unmapped or read-only: ignored
						end
					endcase
				end
			end
			SCG_BUS_RD_WAIT: begin
				s_nxt.rdata = rd_mux;
			end
			SCG_BUS_IDLE, SCG_BUS_RD_DONE: begin
				s_nxt.rdata = s_r.rdata;
			end
		endcase

		// One wait state on reads keeps read data straight from a flip-flop
		if (s_r.bus == SCG_BUS_RD_WAIT) begin
			s_nxt.bus = SCG_BUS_RD_DONE;
		end else if (addr_take) begin
			s_nxt.bus  = i_hwrite ? SCG_BUS_WRITE : SCG_BUS_RD_WAIT;
			s_nxt.addr = i_haddr[13:2];
		end else begin
			s_nxt.bus = SCG_BUS_IDLE;
		end

		// combine bit picks independent or summed
		if (s_r.settings[SCG_SET_COMBINE_BIT]) begin
			s_nxt.ch_a = s_r.src_ch_a ? osc_sum_sat : i_channel_a_data;
			s_nxt.ch_b = s_r.src_ch_b ? osc_sum_sat : i_channel_b_data;
		end else begin
			s_nxt.ch_a = s_r.src_ch_a ? osc_a.sample : i_channel_a_data;
			s_nxt.ch_b = s_r.src_ch_b ? osc_b.sample : i_channel_b_data;
		end
	end

	// State register with synchronous reset
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			s_r <= SCG_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Bus answers: always OKAY, stall only during the read wait
	assign o_hrdata    = s_r.rdata;
	assign o_hreadyout = (s_r.bus != SCG_BUS_RD_WAIT);
	assign o_hresp     = 1'b0;

	// Channel samples and enables
	assign o_channel_a_sample = s_r.ch_a;
	assign o_channel_b_sample = s_r.ch_b;
	assign o_osc_enable       = s_r.osc_enable;
	// transmit is pin or register bit
	assign o_transmit_active  = i_transmit_enable | s_r.tx_enable;

endmodule : scg_synth_regs
`default_nettype wire

/* rtl/scg_pkg.sv */
// Package: register map, field layout, reset values and types of the synthesizer register bank
package scg_pkg;

	// Register indices; byte address is four times the index
	localparam logic [11:0] SCG_IDX_SETTINGS    = 12'h331;
	localparam logic [11:0] SCG_IDX_GAIN_A      = 12'h332;
	localparam logic [11:0] SCG_IDX_GAIN_B      = 12'h334;
	localparam logic [11:0] SCG_IDX_CONTROL     = 12'h338;
	localparam logic [11:0] SCG_IDX_DITHER      = 12'h339;
	localparam logic [11:0] SCG_IDX_SOURCE      = 12'h33A;
	localparam logic [11:0] SCG_IDX_STAT_GAIN_A = 12'h33C;
	localparam logic [11:0] SCG_IDX_STAT_GAIN_B = 12'h33D;
	localparam logic [11:0] SCG_IDX_HOP_BASE    = 12'h400;
	localparam int          SCG_HOP_STRIDE      = 4;
	localparam int          SCG_HOP_DEPTH       = 16;

	// Field positions
	localparam int SCG_SET_COMBINE_BIT  = 0;
	localparam int SCG_SET_DITHER_BIT   = 1;
	localparam int SCG_CTL_OSC_EN_BIT   = 0;
	localparam int SCG_CTL_TX_EN_BIT    = 1;
	localparam int SCG_CTL_HOP_SEL_LSB  = 4;
	localparam int SCG_DITH_LVL_B_LSB   = 4;
	localparam int SCG_SRC_CH_A_BIT     = 0;
	localparam int SCG_SRC_CH_B_BIT     = 1;

	// Reset values
	localparam logic [7:0]  SCG_SETTINGS_RST = 8'h02;
	localparam logic [15:0] SCG_GAIN_RST     = 16'h0003;
	localparam logic [31:0] SCG_HOP_RST      = 32'h0000_0000;

	// Gain arithmetic and dither source
	localparam logic [17:0] SCG_UNITY_GAIN    = 18'h1_0000;
	localparam logic [17:0] SCG_DITH_BACKOFF  = 18'h0_0010;
	localparam logic [15:0] SCG_ROUND_HALF    = 16'h8000;
	localparam logic [15:0] SCG_LFSR_SEED     = 16'hACE1;
	localparam logic [15:0] SCG_LFSR_TAPS     = 16'hB400;

	// Bus slave phases
	typedef enum logic [1:0] {
		SCG_BUS_IDLE,
		SCG_BUS_WRITE,
		SCG_BUS_RD_WAIT,
		SCG_BUS_RD_DONE
	} scg_bus_e;

endpackage : scg_pkg

/* rtl/scg_osc_if.sv */
// Interface: configuration to and results from one oscillator channel
`timescale 1ns/1ns
`default_nettype none
interface scg_osc_if;
	logic [31:0] freq_word;
	logic [15:0] gain_backoff;
	logic [3:0]  dither_level;
	logic        dither_en;
	logic        enable;
	logic [15:0] sample;
	logic [16:0] eff_gain;

	modport ctrl (output freq_word, gain_backoff, dither_level, dither_en, enable, input sample, eff_gain);
	modport osc  (input freq_word, gain_backoff, dither_level, dither_en, enable, output sample, eff_gain);
endinterface : scg_osc_if
`default_nettype wire

/* rtl/scg_osc_chan.sv */
// Module: one oscillator channel with phase accumulator, gain backoff and dither
`timescale 1ns/1ns
`default_nettype none
module scg_osc_chan
	import scg_pkg::*;
(
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_nrst,
	// Configuration and result
	scg_osc_if.osc    osc
);

	typedef struct packed {
		logic [31:0] phase;
		logic [15:0] lfsr;
		logic [15:0] sample;
	} scg_osc_s;

	scg_osc_s    s_r;
	scg_osc_s    s_nxt;
	logic [17:0] backoff;
	logic [16:0] eff_gain;
	logic signed [33:0] product;
	logic signed [33:0] rounded;
	logic [15:0] round_term;

	// Effective gain from programmed and dither backoff
	always_comb begin
		backoff = {2'b00, osc.gain_backoff} + 18'(SCG_DITH_BACKOFF * osc.dither_level);
		if (backoff >= SCG_UNITY_GAIN) begin
			eff_gain = 17'h0_0000;
		end else begin
			eff_gain = 17'(SCG_UNITY_GAIN - backoff);
		end
	end

	assign osc.eff_gain = eff_gain;
	assign osc.sample   = s_r.sample;

	// Next state; the sawtooth amplitude is the top half of the phase
	always_comb begin
		s_nxt = s_r;
		product = $signed(s_r.phase[31:16]) * $signed({1'b0, eff_gain});
		round_term = osc.dither_en ? s_r.lfsr : SCG_ROUND_HALF;
		rounded = product + $signed({18'h0_0000, round_term});
		// phase steps by the frequency word
		s_nxt.phase  = s_r.phase + osc.freq_word;
		s_nxt.lfsr   = s_r.lfsr[0] ? ((s_r.lfsr >> 1) ^ SCG_LFSR_TAPS) : (s_r.lfsr >> 1);
		s_nxt.sample = rounded[31:16];
		if (!osc.enable) begin
			s_nxt.phase  = 32'h0000_0000;
			s_nxt.lfsr   = SCG_LFSR_SEED;
			s_nxt.sample = 16'h0000;
		end
	end

	// State register with synchronous reset
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			s_r <= '{phase: 32'h0000_0000, lfsr: SCG_LFSR_SEED, sample: 16'h0000};
		end else begin
			s_r <= s_nxt;
		end
	end

endmodule : scg_osc_chan
`default_nettype wire

/* bench/scg_synth_regs_asserts.sv */
// Checker: bus timing and output relations of the synthesizer register bank
`timescale 1ns/1ns
`default_nettype none
module scg_synth_regs_chk (
	// Watched ports
	input wire logic        i_clk,
	input wire logic        i_nrst,
	input wire logic        i_hsel,
	input wire logic [1:0]  i_htrans,
	input wire logic        i_hwrite,
	input wire logic        i_hready,
	input wire logic [31:0] o_hrdata,
	input wire logic        o_hreadyout,
	input wire logic        o_hresp,
	input wire logic        i_transmit_enable,
	input wire logic        o_transmit_active,
	input wire logic        o_osc_enable,
	input wire logic [15:0] i_channel_a_data,
	input wire logic [15:0] o_channel_a_sample
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	logic take;
	logic rd_ph_r;

	// Transfer taken at this edge
	assign take = i_hsel && i_htrans[1] && i_hready;

	// Read pending until its data phase ends
	always_ff @(posedge i_clk) begin
		if (!i_nrst)
			rd_ph_r <= 1'b0;
		else if (take && !i_hwrite)
			rd_ph_r <= 1'b1;
		else if (o_hreadyout)
			rd_ph_r <= 1'b0;
	end

	a_resp_okay:    assert property (o_hresp == 1'b0) else $error("response not OKAY");
	a_read_wait:    assert property (take && !i_hwrite |=> !o_hreadyout ##1 o_hreadyout)
		else $error("read wait state wrong");
	a_write_nowait: assert property (take && i_hwrite |=> o_hreadyout) else $error("write stalled");
	a_wait_once:    assert property (!o_hreadyout |=> o_hreadyout) else $error("wait longer than one");
	a_ready_idle:   assert property (!rd_ph_r |-> o_hreadyout) else $error("stall without read");
	a_rdata_hold:   assert property (!rd_ph_r |=> $stable(o_hrdata)) else $error("read data moved");
	a_tx_pin:       assert property (i_transmit_enable |-> o_transmit_active) else $error("pin not seen");
	a_osc_quiet:    assert property (!o_osc_enable && $past(!o_osc_enable, 3) &&
		$past(!o_osc_enable) && $past(i_channel_a_data) == 16'h0000 |-> o_channel_a_sample == 16'h0000)
		else $error("sample while oscillator off");

	c_read:  cover property (take && !i_hwrite);
	c_write: cover property (take && i_hwrite);
	c_osc:   cover property (o_osc_enable);
endmodule : scg_synth_regs_chk

bind scg_synth_regs scg_synth_regs_chk i_scg_synth_regs_chk (.i_clk(i_clk), .i_nrst(i_nrst),
	.i_hsel(i_hsel), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready),
	.o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
	.i_transmit_enable(i_transmit_enable), .o_transmit_active(o_transmit_active),
	.o_osc_enable(o_osc_enable), .i_channel_a_data(i_channel_a_data),
	.o_channel_a_sample(o_channel_a_sample));
`default_nettype wire

/* bench/scg_synth_regs_tb_top.sv */
// Testbench: register bank, gain status and oscillator outputs
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
	$display("MISMATCH %s exp %h got %h", nm, e, g); end end
module scg_synth_regs_tb_top;
	import scg_pkg::*;

	logic        i_clk = 1'b0;
	logic        i_nrst = 1'b0;
	logic        i_hsel = 1'b0;
	logic        i_hwrite = 1'b0;
	logic        i_tx = 1'b0;
	logic [1:0]  i_htrans = 2'h0;
	logic [31:0] i_haddr = 32'h0000_0000;
	logic [31:0] i_hwdata = 32'h0000_0000;
	logic [31:0] o_hrdata;
	logic        o_hreadyout;
	logic [15:0] sa;
	logic [15:0] sb;
	logic        o_osc_enable;
	logic        o_tx_act;
	int          n_mismatch = 0;
	int          n_tests = 0;

	// 50 ns clock
	initial forever #25 i_clk = ~i_clk;

	scg_synth_regs i_scg_synth_regs (.i_clk(i_clk), .i_nrst(i_nrst), .i_hsel(i_hsel), .i_haddr(i_haddr),
		.i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2), .i_hwdata(i_hwdata),
		.i_hready(o_hreadyout), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(),
		.i_transmit_enable(i_tx), .i_freq_word_b(32'h1000_0000), .i_channel_a_data(16'h0000),
		.i_channel_b_data(16'h0000), .o_channel_a_sample(sa), .o_channel_b_sample(sb),
		.o_osc_enable(o_osc_enable), .o_transmit_active(o_tx_act));

	task give_verdict;
		$display("Mismatches %0d, checks %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict

	// Ready is judged at the falling edge, so no race with the slave's own update
	task automatic wait_rdy(output logic [31:0] rd);
		int k;
		k = 0;
		@(negedge i_clk);
		while (o_hreadyout !== 1'b1) begin
			k++;
			if (k > 20) begin
				n_mismatch++;
				give_verdict;
			end
			@(negedge i_clk);
		end
		rd = o_hrdata;
		@(posedge i_clk);
	endtask : wait_rdy

	// One single transfer; entered just after a rising edge
	task automatic bus(input logic wr, input logic [11:0] idx, input logic [31:0] wd, output logic [31:0] rd);
		logic [31:0] d;
		i_hsel <= 1'b1;
		i_htrans <= 2'h2;
		i_hwrite <= wr;
		i_haddr <= {18'h0_0000, idx, 2'h0};
		wait_rdy(d);
		i_hsel <= 1'b0;
		i_htrans <= 2'h0;
		i_hwdata <= wd;
		wait_rdy(rd);
	endtask : bus

	task automatic wr(input logic [11:0] idx, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, idx, d, x);
	endtask : wr

	task automatic rchk(input string nm, input logic [11:0] idx, input logic [31:0] e);
		logic [31:0] d;
		bus(1'b0, idx, 32'h0000_0000, d);
		`CHK(nm, e, d)
	endtask : rchk

	task t_reset_vals;
		rchk("settings", SCG_IDX_SETTINGS, {24'h00_0000, SCG_SETTINGS_RST});
		rchk("gain_a", SCG_IDX_GAIN_A, 32'h0000_0003);
		rchk("gain_b", SCG_IDX_GAIN_B, 32'h0000_0003);
		rchk("unmapped", 12'h100, 32'h0000_0000);
	endtask : t_reset_vals

	// Gains change here with oscillators and transmit off
	task t_gain;
		wr(SCG_IDX_GAIN_A, 32'h0000_0100);
		rchk("gain_a_wr", SCG_IDX_GAIN_A, 32'h0000_0100);
		rchk("eff_a", SCG_IDX_STAT_GAIN_A, 32'h0000_FF00);
		wr(SCG_IDX_DITHER, 32'h0000_0021);
		rchk("eff_a_dith", SCG_IDX_STAT_GAIN_A, 32'h0000_FEF0);
		rchk("eff_b_dith", SCG_IDX_STAT_GAIN_B, 32'h0000_FFDD);
		wr(SCG_IDX_SETTINGS, 32'h0000_0001);
		rchk("eff_a_sum", SCG_IDX_STAT_GAIN_A, 32'h0000_FEF0);
		wr(SCG_IDX_GAIN_A, 32'h0000_FFFF);
		wr(SCG_IDX_DITHER, 32'h0000_000F);
		rchk("eff_a_clamp", SCG_IDX_STAT_GAIN_A, 32'h0000_0000);
		wr(SCG_IDX_STAT_GAIN_A, 32'h0000_1234);
		rchk("status_ro", SCG_IDX_STAT_GAIN_A, 32'h0000_0000);
		// Back to the reset backoff, dither levels zero
		wr(SCG_IDX_GAIN_A, 32'h0000_0003);
		wr(SCG_IDX_DITHER, 32'h0000_0000);
	endtask : t_gain

	task t_hop;
		wr(SCG_IDX_HOP_BASE, 32'h1111_2222);
		wr(SCG_IDX_HOP_BASE + 12'(SCG_HOP_STRIDE * 15), 32'hFFFF_0000);
		rchk("hop_first", SCG_IDX_HOP_BASE, 32'h1111_2222);
		rchk("hop_next", SCG_IDX_HOP_BASE + 12'(SCG_HOP_STRIDE), 32'h0000_0000);
		rchk("hop_last", SCG_IDX_HOP_BASE + 12'(SCG_HOP_STRIDE * 15), 32'hFFFF_0000);
	endtask : t_hop

	// Both channels from the oscillators, hop entry 15, dither off
	task automatic t_osc(input logic mode);
		int same;
		int nz;
		same = 0;
		nz = 0;
		wr(SCG_IDX_SETTINGS, {31'h0000_0000, mode});
		wr(SCG_IDX_SOURCE, 32'h0000_0003);
		wr(SCG_IDX_CONTROL, 32'h0000_00F1);
		repeat (16) begin
			@(negedge i_clk);
			same += int'(sa === sb);
			nz += int'(sa !== 16'h0000);
		end
		`CHK("osc_en", 1'b1, o_osc_enable)
		`CHK("osc_runs", 1'b1, nz > 0)
		`CHK("a_eq_b", mode, same == 16)
		@(posedge i_clk);
		wr(SCG_IDX_CONTROL, 32'h0000_0000);
		repeat (4) @(negedge i_clk);
		`CHK("quiet_a", 16'h0000, sa)
		`CHK("quiet_b", 16'h0000, sb)
		@(posedge i_clk);
	endtask : t_osc

	task t_tx;
		i_tx <= 1'b1;
		@(negedge i_clk);
		`CHK("tx_pin", 1'b1, o_tx_act)
		@(posedge i_clk);
		i_tx <= 1'b0;
		wr(SCG_IDX_CONTROL, 32'h0000_0002);
		@(negedge i_clk);
		`CHK("tx_reg", 1'b1, o_tx_act)
		@(posedge i_clk);
	endtask : t_tx

	// Main sequence after two reset cycles
	initial begin
		repeat (2) @(posedge i_clk);
		i_nrst <= 1'b1;
		@(posedge i_clk);
		t_reset_vals;
		t_gain;
		t_hop;
		t_osc(1'b0);
		t_osc(1'b1);
		t_tx;
		give_verdict;
	end

	// Hang guard
	initial begin
		#2000000;
		n_mismatch++;
		give_verdict;
	end
endmodule : scg_synth_regs_tb_top
`default_nettype wire
